/* hw/cbrf_defs.vh */
`ifndef CBRF_DEFS_VH
`define CBRF_DEFS_VH

// ***************************************************************
// operand select codes
// ***************************************************************
`define CBRF_SEL_D0        4'h0
`define CBRF_SEL_D1        4'h1
`define CBRF_SEL_D2        4'h2
`define CBRF_SEL_D3        4'h3
`define CBRF_SEL_A0        4'h4
`define CBRF_SEL_A1        4'h5
`define CBRF_SEL_FB        4'h6
`define CBRF_SEL_SH_FIRST  4'h8
`define CBRF_SEL_SH_LAST   4'hD

// ***************************************************************
// access sizes
// ***************************************************************
`define CBRF_SZ_BYTE_LO    2'h0
`define CBRF_SZ_BYTE_HI    2'h1
`define CBRF_SZ_WORD       2'h2
`define CBRF_SZ_LONG       2'h3

// ***************************************************************
// counts
// ***************************************************************
`define CBRF_BANK_WORDS    7
`define CBRF_SHARED_WORDS  6

// ***************************************************************
// wishbone word indexes (byte address = 4 * index)
// ***************************************************************
`define CBRF_IDX_BANK_LAST 4'h6
`define CBRF_IDX_SH_FIRST  4'h7
`define CBRF_IDX_SH_LAST   4'hC
`define CBRF_IDX_CTRL      4'hD
`define CBRF_IDX_STATUS    4'hE

// ***************************************************************
// field positions and reset values
// ***************************************************************
`define CBRF_CTRL_BANK_BIT 0
`define CBRF_STAT_BANK_BIT 0
`define CBRF_STAT_ILL_BIT  1
`define CBRF_WORD_RESET    16'h0000
`define CBRF_BANK_RESET    1'b0

`endif

/* hw/cbrf_bank.v */
`timescale 1ns/1ps
`default_nettype none
`include "cbrf_defs.vh"

// one bank: four data words, two address words, frame base
module cbrf_bank (
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire         lo_en_i,
	input  wire [2:0]   lo_idx_i,
	input  wire [1:0]   lo_mask_i,
	input  wire [15:0]  lo_data_i,
	input  wire         hi_en_i,
	input  wire [2:0]   hi_idx_i,
	input  wire [15:0]  hi_data_i,
	output reg  [111:0] words_o
);
	reg [15:0] word_r [0:6];
	integer    i;
	integer    j;

	// byte-masked storage; unselected half keeps its value
	always @(posedge clk_i) begin
		for (i = 0; i < `CBRF_BANK_WORDS; i = i + 1) begin
			if (rst_i) begin
				word_r[i] <= `CBRF_WORD_RESET;
			end else if (lo_en_i && lo_idx_i == i[2:0]) begin
				if (lo_mask_i[0]) word_r[i][7:0] <= lo_data_i[7:0];
				if (lo_mask_i[1]) word_r[i][15:8] <= lo_data_i[15:8];
			end else if (hi_en_i && hi_idx_i == i[2:0]) begin
				word_r[i] <= hi_data_i; // upper word of a pair
			end
		end
	end

	// flatten for the read side
	always @* begin
		words_o = 112'h0;
		for (j = 0; j < `CBRF_BANK_WORDS; j = j + 1) begin
			words_o[j*16 +: 16] = word_r[j];
		end
	end
endmodule

`default_nettype wire

/* hw/cbrf_operand_mux.v */
`timescale 1ns/1ps
`default_nettype none
`include "cbrf_defs.vh"

// operand read selection by code and size
module cbrf_operand_mux (
	input  wire [3:0]   sel_i,
	input  wire [1:0]   size_i,
	input  wire [111:0] bank_words_i,
	input  wire [95:0]  shared_words_i,
	output reg  [31:0]  data_o,
	output reg          illegal_o
);
	// bank word named by the low code bits, shared by the two byte cases
	reg [15:0] word_sel;
	// picks one bank word by index
	function [15:0] pick;
		input [111:0] w;
		input [2:0]   idx;
		begin
			pick = w[idx*16 +: 16];
		end
	endfunction

	// size and pairing decode
	always @* begin
		data_o = 32'h0;
		illegal_o = 1'b0;
		word_sel = pick(bank_words_i, sel_i[2:0]);
		case (size_i)
			`CBRF_SZ_BYTE_LO: begin
				if (sel_i == `CBRF_SEL_D0 || sel_i == `CBRF_SEL_D1)
					data_o = {24'h0, word_sel[7:0]};
				else
					illegal_o = 1'b1;
			end
			`CBRF_SZ_BYTE_HI: begin
				if (sel_i == `CBRF_SEL_D0 || sel_i == `CBRF_SEL_D1)
					data_o = {24'h0, word_sel[15:8]};
				else
					illegal_o = 1'b1;
			end
			`CBRF_SZ_WORD: begin
				if (sel_i <= `CBRF_SEL_FB)
					data_o = {16'h0, pick(bank_words_i, sel_i[2:0])};
				else if (sel_i >= `CBRF_SEL_SH_FIRST && sel_i <= `CBRF_SEL_SH_LAST)
					data_o = {16'h0, shared_words_i[(sel_i - 4'h8)*16 +: 16]};
				else
					illegal_o = 1'b1;
			end
			default: begin
				case (sel_i)
					`CBRF_SEL_D0: data_o = {pick(bank_words_i, 3'h2),
						pick(bank_words_i, 3'h0)};
					`CBRF_SEL_D1: data_o = {pick(bank_words_i, 3'h3),
						pick(bank_words_i, 3'h1)};
					`CBRF_SEL_A0: data_o = {pick(bank_words_i, 3'h5),
						pick(bank_words_i, 3'h4)};
					default: illegal_o = 1'b1;
				endcase
			end
		endcase
	end
endmodule

`default_nettype wire

/* hw/cbrf_top.v */
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cbrf_defs.vh"

module cbrf_top (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire        wb_ack_o,
	input  wire        cpu_wr_en_i,
	input  wire [3:0]  cpu_wr_sel_i,
	input  wire [1:0]  cpu_wr_size_i,
	input  wire [31:0] cpu_wr_data_i,
	input  wire [3:0]  cpu_rd_sel_i,
	input  wire [1:0]  cpu_rd_size_i,
	output wire [31:0] cpu_rd_data_o,
	input  wire        bank_load_i,
	input  wire        bank_val_i,
	output wire        bank_sel_o,
	output wire [15:0] addr_base0_o,
	output wire [15:0] addr_base1_o,
	output wire [31:0] long_addr_o,
	output wire [15:0] frame_base_o
);
	// ***************************************************************
	// state
	// ***************************************************************
	reg         ack_r;
	reg  [31:0] wb_dat_r;
	reg  [31:0] rd_data_r;
	reg         bank_r;
	reg         ill_r;
	reg  [15:0] shared_r [0:5];
	wire [111:0] words0;
	wire [111:0] words1;
	wire [111:0] act_words;
	reg  [95:0]  shared_flat;
	wire [31:0]  rd_mux;
	wire         rd_ill;
	integer      i;
	integer      j;

	// ***************************************************************
	// wishbone decode
	// ***************************************************************
	// word index from the byte address; a request outside the map is still
	// acked, so a stray access can never hang the bus
	wire [3:0] wb_idx = wb_adr_i[5:2];
	wire       wb_hit = wb_adr_i[7:6] == 2'h0;
	wire       wb_req = wb_cyc_i & wb_stb_i;
	// write takes effect at the edge where ack is seen high
	wire       wb_wr = wb_req & wb_we_i & ack_r & wb_hit;
	wire       wb_bank = wb_wr & (wb_idx <= `CBRF_IDX_BANK_LAST);
	wire       wb_sh = wb_wr & (wb_idx >= `CBRF_IDX_SH_FIRST) &
		(wb_idx <= `CBRF_IDX_SH_LAST);
	wire       wb_ctrl = wb_wr & (wb_idx == `CBRF_IDX_CTRL) & wb_sel_i[0];
	wire       wb_stat = wb_wr & (wb_idx == `CBRF_IDX_STATUS) & wb_sel_i[0];
	wire [3:0] wb_sh_off = wb_idx - `CBRF_IDX_SH_FIRST;

	// ***************************************************************
	// cpu write decode
	// ***************************************************************
	reg        lo_en, hi_en, sh_en, wr_ill;
	reg [2:0]  lo_idx, hi_idx;
	reg [1:0]  lo_mask;
	reg [15:0] lo_data, hi_data;
	reg [3:0]  sh_idx;
	reg [1:0]  sh_mask;
	reg [15:0] sh_data;

	// the bus shares the write port with the cpu; a cpu write that meets a
	// bus write to a bank or shared word in one cycle is lost, so software
	// should touch these words only while the cpu is held
	// refused codes leave every word untouched and raise the illegal flag
	// byte, word and long writes; a bus write wins the cycle
	always @* begin
		lo_en = 1'b0;
		hi_en = 1'b0;
		sh_en = 1'b0;
		wr_ill = 1'b0;
		lo_idx = cpu_wr_sel_i[2:0];
		hi_idx = 3'h0;
		lo_mask = 2'h3;
		lo_data = cpu_wr_data_i[15:0];
		hi_data = cpu_wr_data_i[31:16];
		sh_idx = cpu_wr_sel_i - `CBRF_SEL_SH_FIRST;
		sh_mask = 2'h3;
		sh_data = cpu_wr_data_i[15:0];
		if (wb_bank) begin
			lo_en = 1'b1;
			lo_idx = wb_idx[2:0];
			lo_mask = wb_sel_i[1:0];
			lo_data = wb_dat_i[15:0];
		end else if (wb_sh) begin
			sh_en = 1'b1;
			sh_idx = wb_sh_off;
			sh_mask = wb_sel_i[1:0];
			sh_data = wb_dat_i[15:0];
		end else if (cpu_wr_en_i) begin
			case (cpu_wr_size_i)
				`CBRF_SZ_BYTE_LO: begin
					lo_en = (cpu_wr_sel_i == `CBRF_SEL_D0) |
						(cpu_wr_sel_i == `CBRF_SEL_D1);
					wr_ill = ~lo_en;
					lo_mask = 2'h1;
					lo_data = {8'h00, cpu_wr_data_i[7:0]};
				end
				`CBRF_SZ_BYTE_HI: begin
					lo_en = (cpu_wr_sel_i == `CBRF_SEL_D0) |
						(cpu_wr_sel_i == `CBRF_SEL_D1);
					wr_ill = ~lo_en;
					lo_mask = 2'h2;
					lo_data = {cpu_wr_data_i[7:0], 8'h00};
				end
				`CBRF_SZ_WORD: begin
					lo_en = cpu_wr_sel_i <= `CBRF_SEL_FB;
					sh_en = (cpu_wr_sel_i >= `CBRF_SEL_SH_FIRST) &
						(cpu_wr_sel_i <= `CBRF_SEL_SH_LAST);
					wr_ill = ~lo_en & ~sh_en;
				end
				default: begin
					case (cpu_wr_sel_i)
						`CBRF_SEL_D0: begin
							lo_en = 1'b1;
							hi_en = 1'b1;
							hi_idx = 3'h2;
						end
						`CBRF_SEL_D1: begin
							lo_en = 1'b1;
							hi_en = 1'b1;
							hi_idx = 3'h3;
						end
						`CBRF_SEL_A0: begin
							lo_en = 1'b1;
							hi_en = 1'b1;
							hi_idx = 3'h5;
						end
						default: wr_ill = 1'b1;
					endcase
				end
			endcase
		end
	end

	// ***************************************************************
	// two banks, steered by the single select
	// ***************************************************************
	// both banks see the same decoded write; only the enable is steered, so
	// the inactive bank keeps its contents across any number of switches
	cbrf_bank u_bank0 (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.lo_en_i   (lo_en & ~bank_r),
		.lo_idx_i  (lo_idx),
		.lo_mask_i (lo_mask),
		.lo_data_i (lo_data),
		.hi_en_i   (hi_en & ~bank_r),
		.hi_idx_i  (hi_idx),
		.hi_data_i (hi_data),
		.words_o   (words0)
	);

	cbrf_bank u_bank1 (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.lo_en_i   (lo_en & bank_r),
		.lo_idx_i  (lo_idx),
		.lo_mask_i (lo_mask),
		.lo_data_i (lo_data),
		.hi_en_i   (hi_en & bank_r),
		.hi_idx_i  (hi_idx),
		.hi_data_i (hi_data),
		.words_o   (words1)
	);

	assign act_words = bank_r ? words1 : words0;

	// ***************************************************************
	// shared words, outside any bank
	// ***************************************************************
	// shared words ignore the bank select; they stand for the registers
	// that a bank switch must never disturb
	always @(posedge clk_i) begin
		for (i = 0; i < `CBRF_SHARED_WORDS; i = i + 1) begin
			if (rst_i) begin
				shared_r[i] <= `CBRF_WORD_RESET;
			end else if (sh_en && sh_idx == i[3:0]) begin
				if (sh_mask[0]) shared_r[i][7:0] <= sh_data[7:0];
				if (sh_mask[1]) shared_r[i][15:8] <= sh_data[15:8];
			end
		end
	end

	// flatten shared words for the operand mux
	always @* begin
		shared_flat = 96'h0;
		for (j = 0; j < `CBRF_SHARED_WORDS; j = j + 1) begin
			shared_flat[j*16 +: 16] = shared_r[j];
		end
	end

	// ***************************************************************
	// cpu read port, one cycle latency
	// ***************************************************************
	// code and size seen at one edge give the data on the read port after
	// that edge, taken from the bank that is active then
	cbrf_operand_mux u_rd_mux (
		.sel_i          (cpu_rd_sel_i),
		.size_i         (cpu_rd_size_i),
		.bank_words_i   (act_words),
		.shared_words_i (shared_flat),
		.data_o         (rd_mux),
		.illegal_o      (rd_ill)
	);

	always @(posedge clk_i) begin
		if (rst_i) rd_data_r <= 32'h0;
		else rd_data_r <= rd_mux;
	end

	// ***************************************************************
	// bank select and illegal-access flag
	// ***************************************************************
	// a switch takes effect at the next edge; accesses in the cycle of the
	// load still use the old bank
	// bus write wins over the cpu load in the same cycle
	always @(posedge clk_i) begin
		if (rst_i) bank_r <= `CBRF_BANK_RESET;
		else if (wb_ctrl) bank_r <= wb_dat_i[`CBRF_CTRL_BANK_BIT];
		else if (bank_load_i) bank_r <= bank_val_i;
	end

	// covers refused cpu writes and refused reads alike
	// sticky; a new event wins over a write-one clear
	always @(posedge clk_i) begin
		if (rst_i) ill_r <= 1'b0;
		else ill_r <= (ill_r & ~(wb_stat & wb_dat_i[`CBRF_STAT_ILL_BIT])) |
			(cpu_wr_en_i & wr_ill) | rd_ill;
	end

	// ***************************************************************
	// wishbone slave: ack one cycle after request
	// ***************************************************************
	// ack rises one cycle after the request is seen and lasts one cycle;
	// the read word is latched with the request and holds until the next
	// one, so a slow master still finds it
	reg [31:0] wb_rdata;

	always @* begin
		wb_rdata = 32'h0;
		if (wb_hit && wb_idx <= `CBRF_IDX_BANK_LAST)
			wb_rdata = {16'h0, act_words[wb_idx[2:0]*16 +: 16]};
		else if (wb_hit && wb_idx >= `CBRF_IDX_SH_FIRST && wb_idx <= `CBRF_IDX_SH_LAST)
			wb_rdata = {16'h0, shared_flat[wb_sh_off*16 +: 16]};
		else if (wb_hit && wb_idx == `CBRF_IDX_CTRL)
			wb_rdata = {31'h0, bank_r};
		else if (wb_hit && wb_idx == `CBRF_IDX_STATUS)
			wb_rdata = {30'h0, ill_r, bank_r};
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			wb_dat_r <= 32'h0;
		end else begin
			ack_r <= wb_req & ~ack_r;
			if (wb_req && !ack_r) wb_dat_r <= wb_rdata;
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	// addressing outputs follow the active bank with no register stage;
	// they change in the cycle after a bank switch
	assign wb_ack_o = ack_r;
	assign wb_dat_o = wb_dat_r;
	assign cpu_rd_data_o = rd_data_r;
	assign bank_sel_o = bank_r;
	assign addr_base0_o = act_words[4*16 +: 16];  // indirect base
	assign addr_base1_o = act_words[5*16 +: 16];  // indirect base
	assign long_addr_o = {act_words[5*16 +: 16], act_words[4*16 +: 16]};
	assign frame_base_o = act_words[6*16 +: 16];
endmodule

`default_nettype wire

/* testbench/cbrf_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checker of the banked register file
// ****************************************
module cbrf_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic        wb_ack_o,
	input wire logic        cpu_wr_en_i,
	input wire logic [3:0]  cpu_wr_sel_i,
	input wire logic [1:0]  cpu_wr_size_i,
	input wire logic [31:0] cpu_wr_data_i,
	input wire logic [3:0]  cpu_rd_sel_i,
	input wire logic [1:0]  cpu_rd_size_i,
	input wire logic [31:0] cpu_rd_data_o,
	input wire logic        bank_load_i,
	input wire logic        bank_val_i,
	input wire logic        bank_sel_o,
	input wire logic [15:0] addr_base0_o,
	input wire logic [15:0] addr_base1_o,
	input wire logic [31:0] long_addr_o,
	input wire logic [15:0] frame_base_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// bus handshake and bank control
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_bank_load: assert property (bank_load_i && !wb_cyc_i |=> bank_sel_o == $past(bank_val_i))
		else $error("bank select not loaded");
	a_bank_hold: assert property (!bank_load_i && !wb_cyc_i |=> $stable(bank_sel_o))
		else $error("bank select moved");
	a_base_hold: assert property (!cpu_wr_en_i && !wb_cyc_i && !bank_load_i |=>
		$stable(addr_base0_o) && $stable(addr_base1_o) && $stable(frame_base_o))
		else $error("base output moved without cause");
	// operand paths
	a_word_rw: assert property (cpu_wr_en_i && cpu_wr_size_i == 2'h2 && cpu_wr_sel_i < 4'h7
		&& !wb_cyc_i && !bank_load_i ##1 cpu_rd_size_i == 2'h2
		&& cpu_rd_sel_i == $past(cpu_wr_sel_i) |=> cpu_rd_data_o[15:0] == $past(cpu_wr_data_i[15:0], 2))
		else $error("word write not read back");
	a_byte_zero: assert property (!cpu_rd_size_i[1] |=> cpu_rd_data_o[31:8] == 24'h000000)
		else $error("byte read not zero extended");
	a_long_addr: assert property (long_addr_o == {addr_base1_o, addr_base0_o})
		else $error("long address not paired");
	a_long_read: assert property (cpu_rd_size_i == 2'h3 && cpu_rd_sel_i == 4'h4
		|=> cpu_rd_data_o == $past(long_addr_o))
		else $error("long address read wrong");
	c_bank: cover property (bank_load_i && bank_val_i);
	c_long: cover property (cpu_wr_en_i && cpu_wr_size_i == 2'h3);
	c_bus_wr: cover property (wb_ack_o && wb_we_i);
endmodule

bind cbrf_top cbrf_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .cpu_wr_en_i(cpu_wr_en_i),
	.cpu_wr_sel_i(cpu_wr_sel_i), .cpu_wr_size_i(cpu_wr_size_i), .cpu_wr_data_i(cpu_wr_data_i),
	.cpu_rd_sel_i(cpu_rd_sel_i), .cpu_rd_size_i(cpu_rd_size_i), .cpu_rd_data_o(cpu_rd_data_o),
	.bank_load_i(bank_load_i), .bank_val_i(bank_val_i), .bank_sel_o(bank_sel_o),
	.addr_base0_o(addr_base0_o), .addr_base1_o(addr_base1_o), .long_addr_o(long_addr_o),
	.frame_base_o(frame_base_o));
`default_nettype wire

/* testbench/cbrf_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module cbrf_top_bench;
	logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0, cpu_wr_sel_i = 4'h0, cpu_rd_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, cpu_wr_data_i = 32'h0;
	logic [1:0]  cpu_wr_size_i = 2'h0, cpu_rd_size_i = 2'h0;
	logic        cpu_wr_en_i = 1'b0, bank_load_i = 1'b0, bank_val_i = 1'b0;
	wire         wb_ack_o, bank_sel_o;
	wire [31:0]  wb_dat_o, cpu_rd_data_o, long_addr_o;
	wire [15:0]  addr_base0_o, addr_base1_o, frame_base_o;
	logic [15:0] m [0:1][0:13];
	logic [31:0] q_cpu [$], q_bus [$], w;
	logic [80:0] q_base [$];
	logic        rd_req = 1'b0, rd_tk = 1'b0, bk = 1'b0, base_req = 1'b0;
	int          errors = 0, checked = 0, ticks = 0, i, s, h;
	cbrf_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_wr_en_i(cpu_wr_en_i),
		.cpu_wr_sel_i(cpu_wr_sel_i), .cpu_wr_size_i(cpu_wr_size_i), .cpu_wr_data_i(cpu_wr_data_i),
		.cpu_rd_sel_i(cpu_rd_sel_i), .cpu_rd_size_i(cpu_rd_size_i), .cpu_rd_data_o(cpu_rd_data_o),
		.bank_load_i(bank_load_i), .bank_val_i(bank_val_i), .bank_sel_o(bank_sel_o),
		.addr_base0_o(addr_base0_o), .addr_base1_o(addr_base1_o), .long_addr_o(long_addr_o),
		.frame_base_o(frame_base_o));
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	// ****************************************
	// drivers and checks
	// ****************************************
	task automatic complete_run;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic cmp_cpu(input logic [31:0] e);
		checked++;
		if (cpu_rd_data_o !== e) begin
			errors++;
			$display("unexpected cpu data at %0t: %h not %h", $time, cpu_rd_data_o, e);
		end
	endtask
	task automatic cmp_bus(input logic [31:0] e);
		checked++;
		if (wb_dat_o !== e) begin
			errors++;
			$display("unexpected bus data at %0t: %h not %h", $time, wb_dat_o, e);
		end
	endtask
	task automatic cmp_base(input logic [80:0] e);
		logic [80:0] g;
		g = {bank_sel_o, frame_base_o, addr_base1_o, addr_base0_o, long_addr_o};
		checked++;
		if (g !== e) begin
			errors++;
			$display("unexpected base outputs at %0t: %h not %h", $time, g, e);
		end
	endtask
	task automatic base_chk(input logic [80:0] e);
		q_base.push_back(e);
		base_req <= 1'b1;
		@(posedge clk_i);
		base_req <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic cpu_wr(input logic [3:0] sl, input logic [1:0] z, input logic [31:0] d);
		cpu_wr_en_i <= 1'b1;
		cpu_wr_sel_i <= sl;
		cpu_wr_size_i <= z;
		cpu_wr_data_i <= d;
		@(posedge clk_i);
		cpu_wr_en_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic cpu_rd(input logic [3:0] sl, input logic [1:0] z, input logic [31:0] e);
		cpu_rd_sel_i <= sl;
		cpu_rd_size_i <= z;
		rd_req <= 1'b1;
		q_cpu.push_back(e);
		@(posedge clk_i);
		rd_req <= 1'b0;
		@(posedge clk_i);
	endtask
	// classic cycle: hold until ack is seen, release at that edge
	task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] sl,
		input logic [31:0] d, input logic [31:0] e);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= sl;
		wb_dat_i <= d;
		if (!we) q_bus.push_back(e);
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	function automatic logic [15:0] mv(int k);
		return m[(k >= 8) ? 0 : bk][k];
	endfunction
	function automatic logic [7:0] ad(int k);
		return 8'((k < 8 ? k : k - 1) * 4);
	endfunction
	function automatic logic [80:0] bx();
		return {bk, mv(6), mv(5), mv(4), mv(5), mv(4)};
	endfunction
	// result watcher: oldest note against each result
	always @(posedge clk_i) begin
		rd_tk <= rd_req;
		ticks <= ticks + 1;
		if (ticks == 3000) begin
			errors++;
			complete_run;
		end
	end
	always @(negedge clk_i) begin
		if (rd_tk) cmp_cpu(q_cpu.pop_front());
		if (wb_ack_o && !wb_we_i) cmp_bus(q_bus.pop_front());
		if (base_req) cmp_base(q_base.pop_front());
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		w = $urandom(32'hC6480984);
		for (i = 0; i < 28; i++) m[i / 14][i % 14] = 16'h0000;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 7; i++) cpu_rd(i[3:0], 2'h2, 32'h0);
		wb(1'b0, 8'h38, 4'hF, 32'h0, 32'h0);
		// every word of bank and shared area, cpu and bus views
		for (i = 0; i < 14; i++) if (i != 7) begin
			w = $urandom;
			cpu_wr(i[3:0], 2'h2, w);
			m[0][i] = w[15:0];
			cpu_rd(i[3:0], 2'h2, {16'h0, mv(i)});
			wb(1'b0, ad(i), 4'hF, 32'h0, {16'h0, mv(i)});
		end
		// byte halves leave the other half alone
		for (i = 0; i < 4; i++) begin
			w = $urandom;
			cpu_wr({3'h0, i[1]}, {1'b0, i[0]}, w);
			if (i[0]) m[0][i[1]][15:8] = w[7:0];
			else m[0][i[1]][7:0] = w[7:0];
			cpu_rd({3'h0, i[1]}, {1'b0, i[0]}, {24'h0, w[7:0]});
			cpu_rd({3'h0, i[1]}, 2'h2, {16'h0, m[0][i[1]]});
		end
		// long pairs: data low, data high, address
		for (i = 0; i < 3; i++) begin
			s = (i == 2) ? 4 : i;
			h = (i == 2) ? 5 : i + 2;
			w = $urandom;
			cpu_wr(s[3:0], 2'h3, w);
			m[0][s] = w[15:0];
			m[0][h] = w[31:16];
			cpu_rd(s[3:0], 2'h3, w);
			cpu_rd(h[3:0], 2'h2, {16'h0, w[31:16]});
		end
		base_chk(bx());
		// second bank, shared words untouched, then back over the bus
		bank_load_i <= 1'b1;
		bank_val_i <= 1'b1;
		@(posedge clk_i);
		bank_load_i <= 1'b0;
		bk = 1'b1;
		@(posedge clk_i);
		base_chk(bx());
		cpu_rd(4'h0, 2'h2, 32'h0);
		cpu_rd(4'h8, 2'h2, {16'h0, mv(8)});
		wb(1'b0, 8'h38, 4'hF, 32'h0, 32'h1);
		w = $urandom;
		cpu_wr(4'h0, 2'h2, w);
		m[1][0] = w[15:0];
		cpu_rd(4'h0, 2'h2, {16'h0, mv(0)});
		wb(1'b1, 8'h34, 4'h1, 32'h0, 32'h0);
		bk = 1'b0;
		cpu_rd(4'h0, 2'h2, {16'h0, mv(0)});
		base_chk(bx());
		// byte write on a word without halves is refused and flagged
		cpu_wr(4'h2, 2'h0, 32'hFF);
		cpu_rd(4'h2, 2'h2, {16'h0, mv(2)});
		wb(1'b0, 8'h38, 4'hF, 32'h0, 32'h2);
		// write one clears the flag, a refused read raises it again
		wb(1'b1, 8'h38, 4'h1, 32'h2, 32'h0);
		wb(1'b0, 8'h38, 4'hF, 32'h0, 32'h0);
		cpu_rd(4'h7, 2'h2, 32'h0);
		wb(1'b0, 8'h38, 4'hF, 32'h0, 32'h2);
		wb(1'b0, 8'h3C, 4'hF, 32'h0, 32'h0);
		wb(1'b0, 8'h40, 4'hF, 32'h0, 32'h0);
		complete_run;
	end
endmodule
`default_nettype wire
